// File: cto_defs.svh
`ifndef CTO_DEFS_SVH
`define CTO_DEFS_SVH
// ==========================================================
// Reset values and field layout
`define CTO_ACC_RST       8'h00
`define CTO_TIMER0_MODE_REG_RST      8'h00
`define CTO_TABLE_HIGH_POINTER_RST      8'h00
`define CTO_TABLE_HIGH_DATA_RST      6'h00
`define CTO_ZERO_RST      1'b0
`define CTO_TABLE_HIGH_POINTER_LO       3
`define CTO_TABLE_HIGH_DATA_W        6
`define CTO_ROM_LO_MSB    7
`define CTO_ROM_HI_LSB    8
`define CTO_ROM_HI_MSB    13
`endif

// File: cto_pkg.sv
package cto_pkg;
  // ==========================================================
  // Operation codes
  typedef enum logic [2:0] {
    CTO_NOP   = 3'b000,
    CTO_T0LD  = 3'b001,
    CTO_T0RD  = 3'b010,
    CTO_TBL   = 3'b011,
    CTO_XORR  = 3'b100,
    CTO_XORI  = 3'b101
  } cto_op_t;

  typedef struct packed {
    cto_op_t    op;
    logic       dest;
    logic [6:0] reg_idx;
    logic [7:0] imm;
  } cto_cmd_t;

  typedef struct packed {
    logic       we;
    logic [6:0] idx;
    logic [7:0] data;
  } cto_fwr_t;

  typedef enum logic {
    CTO_IDLE  = 1'b0,
    CTO_FETCH = 1'b1
  } cto_st_t;
endpackage : cto_pkg

// File: cto_xor_unit.sv
`timescale 1ns/10ps
module cto_xor_unit
  import cto_pkg::*;
#(
  parameter int W = 8
) (
  // Operands
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  // Result
  output logic      [W-1:0] y,
  output logic              zero
);
  initial begin
    if (W < 1) $error("width must be positive");
  end

  always_comb begin
    y    = a ^ b;
    zero = (y == '0);
  end
endmodule : cto_xor_unit

// File: cto_exec.sv
`timescale 1ns/10ps
`include "cto_defs.svh"
// Contract
// - The timer-mode load copies the accumulator into timer0_mode_reg in one cycle, no flags.
// - Table read addresses ROM with {table_high_pointer[2:0], accumulator}, two cycles, no flags.
// - Table read puts ROM bits 7..0 into accumulator and bits 13..8 into table_high_data[5:0].
// - The timer-mode read copies timer0_mode_reg into the accumulator in one cycle, no flags.
// - Register XOR of accumulator with file register 0..127; dest 0 to accumulator, 1 to register.
// - Immediate XOR of accumulator with an 8-bit operand writes the accumulator.
module cto_exec
  import cto_pkg::*;
#(
  parameter int ROM_AW = 11
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // Command
  input  wire cto_cmd_t          cmd,
  input  wire logic              cmd_valid,
  output logic                   busy,
  // Pointer load
  input  wire logic              ptr_we,
  input  wire logic [7:0]        ptr_data,
  // File register read data for the indexed register
  input  wire logic [7:0]        freg_rdata,
  // ROM port
  output logic [ROM_AW-1:0]      rom_addr,
  output logic                   rom_rd,
  input  wire logic [13:0]       rom_data,
  // Results
  output logic [7:0]             accumulator,
  output logic [7:0]             timer0_mode_reg,
  output logic [7:0]             table_high_pointer,
  output logic [`CTO_TABLE_HIGH_DATA_W-1:0] table_high_data,
  output logic                   zero_flag,
  output logic                   zero_we,
  output cto_fwr_t               freg_wr
);
  initial begin
    if (ROM_AW != `CTO_TABLE_HIGH_POINTER_LO + 8) $error("ROM_AW must be pointer bits plus 8");
  end

  // ==========================================================
  // State
  cto_st_t                  st_r, st_nxt;
  logic [7:0]               acc_r, acc_nxt;
  logic [7:0]               t0_r, t0_nxt;
  logic [7:0]               hp_r, hp_nxt;
  logic [`CTO_TABLE_HIGH_DATA_W-1:0]   hd_r, hd_nxt;
  logic                     z_r, z_nxt;
  logic                     zwe_r, zwe_nxt;
  logic [ROM_AW-1:0]        ra_r, ra_nxt;
  logic                     rrd_r, rrd_nxt;
  cto_fwr_t                 fw_r, fw_nxt;
  logic [7:0]               xb, xy;
  logic                     xz;
  logic                     go;

  assign go = cmd_valid && (st_r == CTO_IDLE);
  assign xb = (cmd.op == CTO_XORI) ? cmd.imm : freg_rdata;

  cto_xor_unit #(.W(8)) u_xor (
    .a    (acc_r),
    .b    (xb),
    .y    (xy),
    .zero (xz)
  );

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt  = st_r;
    acc_nxt = acc_r;
    t0_nxt  = t0_r;
    hp_nxt  = ptr_we ? ptr_data : hp_r;
    hd_nxt  = hd_r;
    z_nxt   = z_r;
    zwe_nxt = 1'b0;
    ra_nxt  = ra_r;
    rrd_nxt = 1'b0;
    fw_nxt  = '0;
    if (st_r == CTO_FETCH) begin
      acc_nxt = rom_data[`CTO_ROM_LO_MSB:0];
      hd_nxt  = rom_data[`CTO_ROM_HI_MSB:`CTO_ROM_HI_LSB];
      st_nxt  = CTO_IDLE;
    end else if (go) begin
      unique case (cmd.op)
        CTO_NOP: begin
        end
        CTO_T0LD: begin
          t0_nxt = acc_r;
        end
        CTO_T0RD: begin
          acc_nxt = t0_r;
        end
        CTO_TBL: begin
          ra_nxt  = {hp_r[`CTO_TABLE_HIGH_POINTER_LO-1:0], acc_r};
          rrd_nxt = 1'b1;
          st_nxt  = CTO_FETCH;
        end
        CTO_XORR: begin
          if (cmd.dest) begin
            fw_nxt = '{we: 1'b1, idx: cmd.reg_idx, data: xy};
          end else begin
            acc_nxt = xy;
          end
          z_nxt   = xz;
          zwe_nxt = 1'b1;
        end
        CTO_XORI: begin
          acc_nxt = xy;
          z_nxt   = xz;
          zwe_nxt = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r  <= CTO_IDLE;
      acc_r <= `CTO_ACC_RST;
      t0_r  <= `CTO_TIMER0_MODE_REG_RST;
      hp_r  <= `CTO_TABLE_HIGH_POINTER_RST;
      hd_r  <= `CTO_TABLE_HIGH_DATA_RST;
      z_r   <= `CTO_ZERO_RST;
      zwe_r <= 1'b0;
      ra_r  <= '0;
      rrd_r <= 1'b0;
      fw_r  <= '0;
    end else if (clk_en) begin
      st_r  <= st_nxt;
      acc_r <= acc_nxt;
      t0_r  <= t0_nxt;
      hp_r  <= hp_nxt;
      hd_r  <= hd_nxt;
      z_r   <= z_nxt;
      zwe_r <= zwe_nxt;
      ra_r  <= ra_nxt;
      rrd_r <= rrd_nxt;
      fw_r  <= fw_nxt;
    end
  end

  // Busy must be registered: high in the fetch cycle
  assign busy               = (st_r == CTO_FETCH);
  assign accumulator        = acc_r;
  assign timer0_mode_reg    = t0_r;
  assign table_high_pointer = hp_r;
  assign table_high_data    = hd_r;
  assign zero_flag          = z_r;
  assign zero_we            = zwe_r;
  assign rom_addr           = ra_r;
  assign rom_rd             = rrd_r;
  assign freg_wr            = fw_r;

  // ==========================================================
  // Checks
  t0_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && go && cmd.op == CTO_T0LD |=> t0_r == $past(acc_r))
    else $error("timer mode load wrong");
  t0_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && go && cmd.op == CTO_T0RD |=> acc_r == $past(t0_r) && z_r == $past(z_r))
    else $error("timer mode read wrong");
  tbl_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && go && cmd.op == CTO_TBL |=> rom_rd && busy
      && rom_addr == {$past(hp_r[2:0]), $past(acc_r)})
    else $error("table address wrong");
  tbl_data_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && busy |=> !busy && acc_r == $past(rom_data[7:0])
      && hd_r == $past(rom_data[13:8]))
    else $error("table data wrong");
  tbl_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && go && cmd.op == CTO_TBL |=> !zero_we ##1 !zero_we)
    else $error("table read touched flags");
  xor_reg_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && go && cmd.op == CTO_XORR && cmd.dest |=> freg_wr.we
      && freg_wr.data == ($past(acc_r) ^ $past(freg_rdata)) && acc_r == $past(acc_r))
    else $error("register xor wrong");
  xor_imm_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && go && cmd.op == CTO_XORI |=> acc_r == ($past(acc_r) ^ $past(cmd.imm))
      && !freg_wr.we)
    else $error("immediate xor wrong");
  xor_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    zero_we |-> zero_flag == ((acc_r == 8'h00 && !freg_wr.we)
      || (freg_wr.we && freg_wr.data == 8'h00)))
    else $error("zero flag wrong");
  xor_acc_dest_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && go && cmd.op == CTO_XORR && !cmd.dest |=> !freg_wr.we
      && acc_r == ($past(acc_r) ^ $past(freg_rdata)))
    else $error("register xor to accumulator wrong");
  xor_reg_idx_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && go && cmd.op == CTO_XORR && cmd.dest |=> freg_wr.idx == $past(cmd.reg_idx))
    else $error("register xor index wrong");
  xor_reg_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && go && cmd.op == CTO_XORR |=> zero_we && $stable(table_high_data))
    else $error("register xor flag update missing");
  xor_imm_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && go && cmd.op == CTO_XORI |=> zero_we && zero_flag == (acc_r == 8'h00))
    else $error("immediate xor zero flag wrong");
  t0_load_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && go && cmd.op == CTO_T0LD |=> !zero_we && $stable(zero_flag)
      && $stable(accumulator))
    else $error("timer mode load touched flags");
  tbl_zero_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && go && cmd.op == CTO_TBL |=> $stable(zero_flag) ##1 $stable(zero_flag))
    else $error("table read changed zero flag");
  tbl_refuse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && busy |=> !freg_wr.we && $stable(timer0_mode_reg))
    else $error("command taken during table fetch");
  rom_rd_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && rom_rd |=> !rom_rd)
    else $error("rom read strobe too long");
  state_freeze_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !clk_en |=> $stable(acc_r) && $stable(t0_r) && $stable(hp_r)
      && $stable(hd_r) && $stable(z_r) && $stable(st_r)
      && $stable(fw_r) && $stable(zwe_r))
    else $error("state moved while clock enable low");
endmodule : cto_exec

// File: cto_exec_tb_top.sv
`timescale 1ns/10ps
module cto_exec_tb_top;
  import cto_pkg::*;
  // ==========================================================
  // Design hookup
  logic        ref_clk, rst_n, clk_en, cmd_valid, busy, ptr_we, rom_rd;
  logic        zero_flag, zero_we;
  cto_cmd_t    cmd;
  cto_fwr_t    freg_wr;
  logic [7:0]  ptr_data, freg_rdata, accumulator, timer0_mode_reg, table_high_pointer;
  logic [10:0] rom_addr;
  logic [13:0] rom_data;
  logic [5:0]  table_high_data;
  logic [7:0]  acc_m;
  int          mismatches, tests_run, cycles;

  // Bench ROM pattern
  assign rom_data = {rom_addr[10:5], rom_addr[7:0] ^ 8'h5a};

  cto_exec #(.ROM_AW(11)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .cmd(cmd), .cmd_valid(cmd_valid), .busy(busy), .ptr_we(ptr_we), .ptr_data(ptr_data),
    .freg_rdata(freg_rdata), .rom_addr(rom_addr), .rom_rd(rom_rd), .rom_data(rom_data),
    .accumulator(accumulator), .timer0_mode_reg(timer0_mode_reg),
    .table_high_pointer(table_high_pointer), .table_high_data(table_high_data),
    .zero_flag(zero_flag), .zero_we(zero_we), .freg_wr(freg_wr));

  // ==========================================================
  // Shared tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task issue(input cto_op_t op, input logic d, input logic [7:0] imm, input logic [7:0] fr);
    @(negedge ref_clk);
    cmd = '{op, d, 7'h7f, imm};
    freg_rdata = fr;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask : issue

  task results;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  // ==========================================================
  // Scenarios
  task t_xori(input logic [7:0] imm);
    issue(CTO_XORI, 1'b0, imm, 8'h00);
    acc_m = acc_m ^ imm;
    chk(accumulator, acc_m);
    chk(zero_flag, acc_m == 8'h00);
    chk(zero_we, 1'b1);
  endtask : t_xori

  task t_xorr(input logic d, input logic [7:0] fr);
    logic [7:0] r;
    r = acc_m ^ fr;
    issue(CTO_XORR, d, 8'h00, fr);
    chk(freg_wr, d ? {1'b1, 7'h7f, r} : 16'h0000);
    if (!d) acc_m = r;
    chk(accumulator, acc_m);
    chk(zero_flag, r == 8'h00);
    chk(zero_we, 1'b1);
  endtask : t_xorr

  task t_timer;
    issue(CTO_T0LD, 1'b0, 8'h00, 8'h00);
    chk(timer0_mode_reg, acc_m);
    chk(zero_we, 1'b0);
    t_xori(8'h3c);
    issue(CTO_T0RD, 1'b0, 8'h00, 8'h00);
    chk(accumulator, acc_m ^ 8'h3c);
    chk(zero_we, 1'b0);
    acc_m = acc_m ^ 8'h3c;
  endtask : t_timer

  task t_table;
    @(negedge ref_clk);
    ptr_we = 1'b1;
    ptr_data = 8'hfa;
    @(negedge ref_clk);
    ptr_we = 1'b0;
    chk(table_high_pointer, 8'hfa);
    cmd = '{CTO_TBL, 1'b0, 7'h00, 8'h00};
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    chk(busy, 1'b1);
    chk(rom_addr, {3'h2, acc_m});
    chk(rom_rd, 1'b1);
    cmd = '{CTO_XORI, 1'b0, 7'h00, 8'hff};
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    chk(accumulator, acc_m ^ 8'h5a);
    chk(table_high_data, {3'h2, acc_m[7:5]});
    chk(zero_we, 1'b0);
    chk(busy, 1'b0);
    chk(rom_rd, 1'b0);
    acc_m = acc_m ^ 8'h5a;
    @(negedge ref_clk);
    chk(accumulator, acc_m);
  endtask : t_table

  task t_idle;
    issue(CTO_NOP, 1'b1, 8'hff, 8'hff);
    chk(accumulator, acc_m);
    chk(freg_wr, 16'h0000);
    chk(zero_we, 1'b0);
    issue(cto_op_t'(3'b110), 1'b1, 8'hff, 8'hff);
    chk(accumulator, acc_m);
    chk(freg_wr, 16'h0000);
    chk(zero_we, 1'b0);
  endtask : t_idle

  task t_reset;
    @(negedge ref_clk);
    rst_n = 1'b0;
    @(negedge ref_clk);
    chk(accumulator, 8'h00);
    chk(timer0_mode_reg, 8'h00);
    chk(table_high_pointer, 8'h00);
    chk(table_high_data, 6'h00);
    chk(zero_flag, 1'b0);
    chk({busy, rom_rd, zero_we}, 3'b000);
    chk(freg_wr, 16'h0000);
    rst_n = 1'b1;
    acc_m = 8'h00;
  endtask : t_reset

  task t_freeze;
    @(negedge ref_clk);
    clk_en = 1'b0;
    cmd = '{CTO_XORI, 1'b0, 7'h00, 8'h81};
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    chk(accumulator, acc_m);
    chk(zero_we, 1'b0);
    clk_en = 1'b1;
    @(negedge ref_clk);
    acc_m = acc_m ^ 8'h81;
    chk(accumulator, acc_m);
    cmd = '{CTO_XORI, 1'b0, 7'h00, 8'h18};
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    acc_m = acc_m ^ 8'h18;
    chk(accumulator, acc_m);
    chk(zero_flag, acc_m == 8'h00);
    chk(zero_we, 1'b1);
  endtask : t_freeze

  // ==========================================================
  // Clock, reset, sequence, timeout
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      results;
    end
  end

  initial begin
    {rst_n, cmd_valid, ptr_we} = 3'b000;
    clk_en = 1'b1;
    cmd = '0;
    ptr_data = 8'h00;
    freg_rdata = 8'h00;
    acc_m = 8'h00;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    t_xori(8'ha5);
    t_xori(8'ha5);
    t_xori(8'hf0);
    t_xorr(1'b1, 8'ha5);
    t_xorr(1'b0, 8'ha5);
    t_xorr(1'b1, acc_m);
    t_timer;
    t_table;
    t_xori(acc_m);
    t_idle;
    t_reset;
    t_xori(8'h00);
    t_freeze;
    t_xori(acc_m);
    results;
  end
endmodule : cto_exec_tb_top
